/* rtl/cgc_regs.sv */
/*
  Global configuration and status registers of a four-channel codec:
  PCM format, ring trip setup, debounced SLIC status and the first
  bidirectional signaling pin.
  Assumes a command decoder presents one command byte with its data
  byte per strobe, and SLIC pins arrive asynchronously.
*/
// Contract
// - Bit 7 clear A-law, set mu-law
// - Bit 6 clear compressed, set linear code
// - Bit 5 clear single, set double clock
// - Edge field selects transmit and sample edges
// - Offset field shifts slots zero to seven
// - Ring polarity picks activating edge direction
// - Off-hook polarity clear low, set high
// - Source select picks first or second input
// - Ring trip enable turns function on
// - Output select picks ring control source
// - Status low nibble is debounced off-hook
// - Status high nibble is debounced ground-key
// - Direction bits set pins input or output
// - Bit 7 sets channel four direction
// - Low nibble reads inputs, drives outputs
module cgc_regs (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 cmd_valid,
  input  wire logic [7:0]           cmd_byte,
  input  wire logic [7:0]           cmd_wdata,
  output logic                      rd_valid_q,
  output logic [7:0]                rd_data_q,
  input  wire logic [3:0]           slic_input_1,
  input  wire logic [3:0]           slic_input_2,
  input  wire logic [3:0]           bidir_signal_pin1_i,
  output logic [3:0]                bidir_signal_pin1_o,
  output logic [3:0]                bidir_signal_pin1_oe,
  output cgc_pkg::cgc_format_t      format_cfg_q,
  output cgc_pkg::cgc_ring_t        ring_cfg_q,
  output logic [3:0]                ring_trip_q
);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic       is_write;
  logic [6:0] cmd_addr;
  logic       soft_hw_rst;
  logic       regs_rst;

  assign is_write    = cmd_valid && cmd_byte[7];
  assign cmd_addr    = cmd_byte[6:0];
  // Hardware reset command clears config, ring trip and pin drive; debounce, synchronisers and read data keep running
  assign soft_hw_rst = is_write && (cmd_addr == cgc_pkg::CGC_ADDR_HWRST);
  assign regs_rst    = !rst_n || soft_hw_rst;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] si1_meta_q, si1_sync_q;
  logic [3:0] si2_meta_q, si2_sync_q;
  logic [3:0] pin_meta_q, pin_sync_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      si1_meta_q <= 4'h0;
      si1_sync_q <= 4'h0;
      si2_meta_q <= 4'h0;
      si2_sync_q <= 4'h0;
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end else begin
      si1_meta_q <= slic_input_1;
      si1_sync_q <= si1_meta_q;
      si2_meta_q <= slic_input_2;
      si2_sync_q <= si2_meta_q;
      pin_meta_q <= bidir_signal_pin1_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Debounce, one filter per channel and input
  // ----------------------------------------------------------------
  logic [3:0] offhook_debounced_bits;
  logic [3:0] groundkey_debounced_bits;

  genvar ch;
  generate
    for (ch = 0; ch < cgc_pkg::CGC_CHANNELS; ch++) begin : g_deb
      logic [cgc_pkg::CGC_DEB_W-1:0] cnt1_q, cnt2_q;
      logic                          st1_q, st2_q;

      // Level must hold a full window before it is believed
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          cnt1_q <= '0;
          st1_q  <= 1'b0;
        end else if (si1_sync_q[ch] == st1_q) begin
          cnt1_q <= '0;
        end else if (cnt1_q == cgc_pkg::CGC_DEB_LAST) begin
          cnt1_q <= '0;
          st1_q  <= si1_sync_q[ch];
        end else begin
          cnt1_q <= cnt1_q + 1'b1;
        end
      end

      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          cnt2_q <= '0;
          st2_q  <= 1'b0;
        end else if (si2_sync_q[ch] == st2_q) begin
          cnt2_q <= '0;
        end else if (cnt2_q == cgc_pkg::CGC_DEB_LAST) begin
          cnt2_q <= '0;
          st2_q  <= si2_sync_q[ch];
        end else begin
          cnt2_q <= cnt2_q + 1'b1;
        end
      end

      assign offhook_debounced_bits[ch]   = st1_q;
      assign groundkey_debounced_bits[ch] = st2_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Format register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (regs_rst) begin
      format_cfg_q <= cgc_pkg::CGC_FORMAT_RST;
    end else if (is_write && cmd_addr == cgc_pkg::CGC_ADDR_FORMAT) begin
      // Law, code, clock mode, edges and offset all land here
      format_cfg_q <= cmd_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Ring trip register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (regs_rst) begin
      ring_cfg_q <= cgc_pkg::CGC_RING_RST;
    end else if (is_write && cmd_addr == cgc_pkg::CGC_ADDR_RING) begin
      ring_cfg_q          <= cmd_wdata;
      // Reserved bit kept at zero so it reads back as zero
      ring_cfg_q.reserved <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Ring trip detection
  // ----------------------------------------------------------------
  logic [3:0] offhook_src;
  logic [3:0] offhook_active;
  logic       sel_bidir1;

  assign offhook_src    = ring_cfg_q.offhook_source_select ?
                          groundkey_debounced_bits :
                          offhook_debounced_bits;
  assign offhook_active = ring_cfg_q.offhook_input_polarity ?
                          offhook_src : ~offhook_src;
  assign sel_bidir1     = ring_cfg_q.ring_output_select ==
                          cgc_pkg::CGC_OSEL_BIDIR1;

  // Level follows the line; other ring sources read it externally
  always_ff @(posedge core_clk) begin
    if (regs_rst) begin
      ring_trip_q <= 4'h0;
    end else begin
      ring_trip_q <= ring_cfg_q.ring_trip_enable ?
                     offhook_active : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // First bidirectional pin register
  // ----------------------------------------------------------------
  cgc_pkg::cgc_bidir_t bidir_q;
  logic [3:0]          trip_force;
  logic                ring_idle_level;

  // Inactive level is the opposite of the activating edge's end
  assign ring_idle_level = !ring_cfg_q.ring_output_polarity;
  assign trip_force      = (ring_cfg_q.ring_trip_enable && sel_bidir1) ?
                           (offhook_active &
                            bidir_q.bidir_pin1_direction) : 4'h0;

  always_ff @(posedge core_clk) begin
    if (regs_rst) begin
      bidir_q <= cgc_pkg::CGC_BIDIR1_RST;
    end else if (is_write && cmd_addr == cgc_pkg::CGC_ADDR_BIDIR1) begin
      bidir_q.bidir_pin1_direction <= cmd_wdata[7:4];
      // Trip wins over a write in the same cycle
      for (int i = 0; i < 4; i++) begin
        bidir_q.data[i] <= trip_force[i] ? ring_idle_level :
                           cmd_wdata[i];
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (trip_force[i]) begin
          bidir_q.data[i] <= ring_idle_level;
        end
      end
    end
  end

  // Pin drive registered so outputs come straight from flops
  always_ff @(posedge core_clk) begin
    if (regs_rst) begin
      bidir_signal_pin1_o  <= 4'h0;
      bidir_signal_pin1_oe <= 4'h0;
    end else begin
      bidir_signal_pin1_o  <= bidir_q.data;
      bidir_signal_pin1_oe <= bidir_q.bidir_pin1_direction;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [3:0] pin_view;

  // Inputs show the pin, outputs show the driven value
  assign pin_view = (bidir_q.bidir_pin1_direction & bidir_q.data) |
                    (~bidir_q.bidir_pin1_direction & pin_sync_q);

  always_comb begin
    rd_mux = cgc_pkg::CGC_UNMAPPED_RD;
    unique case (cmd_addr)
      cgc_pkg::CGC_ADDR_FORMAT: rd_mux = format_cfg_q;
      cgc_pkg::CGC_ADDR_RING:   rd_mux = ring_cfg_q;
      cgc_pkg::CGC_ADDR_SLIC:   rd_mux = {groundkey_debounced_bits,
                                          offhook_debounced_bits};
      cgc_pkg::CGC_ADDR_BIDIR1: rd_mux = {bidir_q.bidir_pin1_direction,
                                          pin_view};
      default:                  rd_mux = cgc_pkg::CGC_UNMAPPED_RD;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= 8'h00;
    end else begin
      rd_valid_q <= cmd_valid && !cmd_byte[7];
      rd_data_q  <= (cmd_valid && !cmd_byte[7]) ? rd_mux : 8'h00;
    end
  end

endmodule

/* rtl/cgc_pkg.sv */
/*
  Constants, field layouts and carrier types of the codec global
  configuration register bank.
  Assumes one 100 MHz core clock and a byte-wide command port.
*/
package cgc_pkg;

  // ----------------------------------------------------------------
  // Command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CGC_WRITE_FLAG  = 8'h80;
  localparam logic [6:0] CGC_ADDR_FORMAT = 7'h26;
  localparam logic [6:0] CGC_ADDR_RING   = 7'h27;
  localparam logic [6:0] CGC_ADDR_SLIC   = 7'h28;
  localparam logic [6:0] CGC_ADDR_BIDIR1 = 7'h29;
  localparam logic [6:0] CGC_ADDR_HWRST  = 7'h23;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CGC_FORMAT_RST  = 8'h00;
  localparam logic [7:0] CGC_RING_RST    = 8'h00;
  localparam logic [7:0] CGC_BIDIR1_RST  = 8'h00;
  localparam logic [7:0] CGC_UNMAPPED_RD = 8'h00;

  // ----------------------------------------------------------------
  // Ring output select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CGC_OSEL_BIDIR1 = 3'h3;
  localparam logic [2:0] CGC_OSEL_BIDIR2 = 3'h4;
  localparam logic [2:0] CGC_OSEL_BIDIR3 = 3'h5;
  localparam logic [2:0] CGC_OSEL_SO1    = 3'h6;
  localparam logic [2:0] CGC_OSEL_SO2    = 3'h7;

  // ----------------------------------------------------------------
  // Debounce timing
  // ----------------------------------------------------------------
  localparam int CGC_CLK_MHZ        = 100;
  localparam int CGC_DEBOUNCE_US    = 8;
  localparam int CGC_DEBOUNCE_CYC   = CGC_DEBOUNCE_US * CGC_CLK_MHZ;
  localparam int CGC_DEB_W          = 10;
  localparam logic [CGC_DEB_W-1:0] CGC_DEB_LAST =
    CGC_DEB_W'(CGC_DEBOUNCE_CYC - 1);
  localparam int CGC_CHANNELS       = 4;

  // ----------------------------------------------------------------
  // Register layouts, msb first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       mu_law;
    logic       voice_format_select;
    logic       double_clk;
    logic [1:0] clk_edge;
    logic [2:0] slot_offset_field;
  } cgc_format_t;

  typedef struct packed {
    logic       ring_output_polarity;
    logic       reserved;
    logic       offhook_input_polarity;
    logic       offhook_source_select;
    logic       ring_trip_enable;
    logic [2:0] ring_output_select;
  } cgc_ring_t;

  typedef struct packed {
    logic [3:0] bidir_pin1_direction;
    logic [3:0] data;
  } cgc_bidir_t;

endpackage

/* dv/cgc_regs_sva.sv */
/*
  Port checker for the codec global configuration register bank.
  Assumes one clock and synchronous active-low reset.
*/
module cgc_regs_sva (
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire logic                 cmd_valid,
  input wire logic [7:0]           cmd_byte,
  input wire logic [7:0]           cmd_wdata,
  input wire logic                 rd_valid_q,
  input wire logic [7:0]           rd_data_q,
  input wire logic [3:0]           bidir_signal_pin1_oe,
  input wire cgc_pkg::cgc_format_t format_cfg_q,
  input wire cgc_pkg::cgc_ring_t   ring_cfg_q,
  input wire logic [3:0]           ring_trip_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic rd_cmd;
  assign rd_cmd = cmd_valid && !cmd_byte[7];

  a_read_answer: assert property (rd_cmd |=> rd_valid_q)
    else $error("read not answered next cycle");
  a_read_quiet: assert property (!rd_cmd
    |=> !rd_valid_q && rd_data_q == 8'h00)
    else $error("read data outside answer");
  a_format_write: assert property (cmd_valid && cmd_byte == 8'hA6
    |=> format_cfg_q == $past(cmd_wdata)) else $error("format write lost");
  a_format_hold: assert property (!(cmd_valid && cmd_byte inside
    {8'hA6, 8'hA3}) |=> $stable(format_cfg_q)) else $error("format moved");
  a_format_read: assert property (cmd_valid && cmd_byte == 8'h26
    |=> rd_data_q == $past(format_cfg_q)) else $error("format read bad");
  a_ring_write: assert property (cmd_valid && cmd_byte == 8'hA7
    |=> ring_cfg_q == ($past(cmd_wdata) & 8'hBF)) else $error("ring write");
  a_ring_resv: assert property (ring_cfg_q.reserved == 1'b0)
    else $error("reserved ring bit set");
  a_pin_dir: assert property (cmd_valid && cmd_byte == 8'hA9 |=> ##1
    bidir_signal_pin1_oe == 4'($past(cmd_wdata, 2) >> 4)) else $error("dir");
  a_trip_off: assert property (!ring_cfg_q.ring_trip_enable
    |=> ring_trip_q == 4'h0) else $error("trip while disabled");

  c_read: cover property (rd_cmd ##1 rd_valid_q);
  c_trip: cover property (ring_trip_q != 4'h0);
  c_pin: cover property (bidir_signal_pin1_oe != 4'h0);
endmodule

bind cgc_regs cgc_regs_sva cgc_regs_sva_i (.core_clk, .rst_n, .cmd_valid,
  .cmd_byte, .cmd_wdata, .rd_valid_q, .rd_data_q, .bidir_signal_pin1_oe,
  .format_cfg_q, .ring_cfg_q, .ring_trip_q);

/* dv/cgc_slic_model.sv */
/*
  Line interface stand-in: hook and ground-key lines and an external
  driver on the first bidirectional pin.
  Assumes the bench sets line states between clock edges.
*/
module cgc_slic_model (
  input  wire logic       core_clk,
  input  wire logic [3:0] hook,
  input  wire logic [3:0] gk,
  input  wire logic [3:0] ext,
  input  wire logic [3:0] oe,
  input  wire logic [3:0] o,
  output logic      [3:0] si1,
  output logic      [3:0] si2,
  output logic      [3:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Device wins where it drives, line driver elsewhere
  assign pin = (oe & o) | (~oe & ext);
  always_ff @(posedge core_clk) begin
    si1 <= hook;
    si2 <= gk;
  end
endmodule

/* dv/test_cgc_regs.sv */
/*
  Self-checking bench for the codec global configuration registers.
  Assumes the line model and the bound port checker.
*/
module test_cgc_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] wc, wd, rc, ex;} cgc_row_t;
  logic                 core_clk = 0, rst_n = 0, cmd_valid = 0, rd_valid_q;
  logic [7:0]           cmd_byte = 8'h00, cmd_wdata = 8'h00, rd_data_q, q;
  logic [3:0]           hook = 4'h0, gk = 4'h0, ext = 4'hA;
  logic [3:0]           si1, si2, pin, pin_o, pin_oe, ring_trip_q;
  cgc_pkg::cgc_format_t format_cfg_q;
  cgc_pkg::cgc_ring_t   ring_cfg_q;
  int                   errors = 0, compares = 0, n;
  cgc_row_t rows [14] = '{32'hA680_2680, 32'hA640_2640, 32'hA620_2620,
    32'hA608_2608, 32'hA610_2610, 32'hA618_2618, 32'hA607_2607,
    32'hA78B_278B, 32'hA736_2736, 32'hA7FF_27BF, 32'hA8FF_2800,
    32'h85FF_0500, 32'hA9F5_29F5, 32'hA985_2982};

  always #5 core_clk = ~core_clk;

  cgc_slic_model cgc_slic_model_i (.core_clk, .hook, .gk, .ext, .oe(pin_oe),
    .o(pin_o), .si1, .si2, .pin);
  cgc_regs cgc_regs_i (.core_clk, .rst_n, .cmd_valid, .cmd_byte, .cmd_wdata,
    .rd_valid_q, .rd_data_q, .slic_input_1(si1), .slic_input_2(si2),
    .bidir_signal_pin1_i(pin), .bidir_signal_pin1_o(pin_o),
    .bidir_signal_pin1_oe(pin_oe), .format_cfg_q, .ring_cfg_q, .ring_trip_q);

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t saw %h wanted %h", $time, got, exp);
    end
  endtask

  // Read data only counts in the answer cycle
  task automatic xfer(input logic [7:0] c, d, output logic [7:0] r);
    @(posedge core_clk);
    #1 cmd_valid = 1;
    cmd_byte = c;
    cmd_wdata = d;
    @(posedge core_clk);
    #1 cmd_valid = 0;
    r = (rd_valid_q === 1'b1) ? rd_data_q : 8'hEE;
  endtask

  task automatic ring(input logic [7:0] cfg, input logic [3:0] ex);
    xfer(8'hA7, cfg, q);
    repeat (2) @(posedge core_clk);
    #1 check({4'h0, ring_trip_q}, {4'h0, ex});
  endtask

  task automatic tally_and_finish;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    #1 rst_n = 1;
    for (int a = 8'h26; a <= 8'h29; a++) begin
      xfer(8'(a), 8'h00, q);
      check(q, (a == 8'h29) ? 8'h0A : 8'h00);
    end
    foreach (rows[i]) begin
      xfer(rows[i].wc, rows[i].wd, q);
      repeat (3) @(posedge core_clk);
      xfer(rows[i].rc, 8'h00, q);
      check(q, rows[i].ex);
    end
    // Back to back write then read, no idle cycle
    @(posedge core_clk);
    #1 cmd_valid = 1;
    cmd_byte = 8'hA6;
    cmd_wdata = 8'h5A;
    @(posedge core_clk);
    #1 cmd_byte = 8'h26;
    @(posedge core_clk);
    #1 cmd_valid = 0;
    check((rd_valid_q === 1'b1) ? rd_data_q : 8'hEE, 8'h5A);
    xfer(8'hA3, 8'hFF, q);
    xfer(8'h26, 8'h00, q);
    check(q, 8'h00);
    // Short hook glitch must be rejected by the debounce
    xfer(8'hA9, 8'h10, q);
    xfer(8'hA7, 8'h2B, q);
    hook = 4'h2;
    repeat (400) @(posedge core_clk);
    #1 hook = 4'h1;
    gk = 4'h2;
    for (n = 0; n < 1000 && ring_trip_q !== 4'h1; n++) begin
      @(posedge core_clk);
      #1;
    end
    if (n == 1000) begin
      $display("FAIL %0t ring trip never rose", $time);
      errors++;
      tally_and_finish();
    end
    repeat (2) @(posedge core_clk);
    #1 check({4'h0, pin_o}, 8'h01);
    xfer(8'h28, 8'h00, q);
    check(q, 8'h21);
    ring(8'h3B, 4'h2);
    ring(8'h1B, 4'hD);
    ring(8'h13, 4'h0);
    // Opposite polarity forces the pin low
    ring(8'hAB, 4'h1);
    check({4'h0, pin_o}, 8'h00);
    // Mid-run reset returns every register to its reset value
    xfer(8'hA6, 8'hC3, q);
    rst_n = 0;
    repeat (3) @(posedge core_clk);
    #1 rst_n = 1;
    check(format_cfg_q, 8'h00);
    check(ring_cfg_q, 8'h00);
    check({pin_oe, pin_o}, 8'h00);
    check({4'h0, ring_trip_q}, 8'h00);
    xfer(8'h26, 8'h00, q);
    check(q, 8'h00);
    tally_and_finish();
  end
endmodule
